// ==== inc/mcu_exec_pkg.sv ====
// Purpose: Shared constants and types for the instruction execution core
// Assumes: Instruction word layout and function codes are local to this core
// Notes: Carry after a subtract is set when no borrow occurred
package mcu_exec_pkg;

  // ****************************************
  // Instruction cycle timing
  // ****************************************
  localparam int PHASES = 4;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_EXEC = 2'h2;
  localparam logic [1:0] PH_LAST = 2'(PHASES - 1);

  // ****************************************
  // Instruction word fields
  // ****************************************
  localparam int INSTR_W = 19;
  localparam int DEST_BIT = 18;
  localparam int FUNC_MSB = 17;
  localparam int FUNC_LSB = 12;
  localparam int BIT_MSB = 10;
  localparam int BIT_LSB = 8;
  localparam int BYTE_MSB = 7;
  localparam int TGT_W = 12;

  // ****************************************
  // Data space and reset values
  // ****************************************
  localparam logic [7:0] PC_LOW_ADDR = 8'h02;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [8:0] BYTE_MAX = 9'h0ff;

  typedef enum logic [5:0] {
    F_NOP, F_TRANSFER, F_TRANSFER_IMM, F_ADD, F_ADD_C, F_ADD_IMM, F_SUBTRACT, F_SUB_C,
    F_SUB_IMM, F_AND, F_OR, F_XOR, F_AND_IMM, F_OR_IMM, F_XOR_IMM, F_INVERT, F_ADD_ONE,
    F_SUB_ONE, F_ROT_R, F_ROT_L, F_ROT_R_C, F_ROT_L_C, F_BIT_CLR, F_BIT_SET, F_CLEAR,
    F_JUMP, F_CALL, F_SUB_EXIT, F_INT_EXIT, F_SKIP_Z, F_SKIP_BIT_Z, F_SKIP_BIT_NZ,
    F_SKIP_INC_Z, F_SKIP_DEC_Z, F_TABLE_RD, F_POWER_DOWN
  } func_t;

  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_FLUSH = 4'b0010,
    ST_TABLE = 4'b0100,
    ST_HALT = 4'b1000
  } state_t;

endpackage

// ==== hw/mcu_instruction_execution.sv ====
// Purpose: Instruction execution and timing of an 8-bit accumulator core
// Assumes: Program and data memories answer within the same instruction cycle
// Notes: Overview of rules below
`timescale 1ns/10ps
module mcu_instruction_execution #(
  parameter int PC_W = 12,
  parameter int STACK_DEPTH = 4
)(
  input logic CLK_IN,
  input logic RESET_IN,
  input logic WAKE_IN,
  output logic [PC_W-1:0] PROG_ADDR_OUT,
  input logic [mcu_exec_pkg::INSTR_W-1:0] PROG_DATA_IN,
  output logic [7:0] DATA_ADDR_OUT,
  input logic [7:0] DATA_RDATA_IN,
  output logic [7:0] DATA_WDATA_OUT,
  output logic DATA_WR_OUT,
  output logic [7:0] ACC_OUT,
  output logic ZERO_OUT,
  output logic CARRY_OUT,
  output logic AUX_CARRY_OUT,
  output logic OVERFLOW_OUT,
  output logic HALTED_OUT,
  output logic CYCLE_END_OUT
);

  localparam int SP_W = $clog2(STACK_DEPTH);

  // ****************************************
  // State
  // ****************************************
  mcu_exec_pkg::state_t state_r, state_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [PC_W-1:0] pc_r, pc_nxt;
  logic [mcu_exec_pkg::INSTR_W-1:0] ir_r, ir_nxt;
  logic [7:0] dm_addr_r, dm_addr_nxt;
  logic [7:0] opnd_r, opnd_nxt;
  logic [7:0] acc_r, acc_nxt;
  logic z_r, z_nxt, c_r, c_nxt, ac_r, ac_nxt, ov_r, ov_nxt;
  logic [7:0] wdata_r, wdata_nxt;
  logic wr_r, wr_nxt;
  logic skip_r, skip_nxt;
  logic [SP_W-1:0] sp_r, sp_nxt;
  logic push;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic wake_meta_r, wake_sync_r;

  // ****************************************
  // Execute datapath
  // ****************************************
  mcu_exec_pkg::func_t func;
  logic dest_mem, is_imm, sub_op, cin, use_d;
  logic [7:0] imm, bsel, addend, res;
  logic [8:0] sum9;
  logic [4:0] half;
  logic a_we, m_we, rz, rc, rac, rov, rskip;
  logic pc_low_wr, cyc_end;

  localparam logic [7:0] BYTE_ONE_F = mcu_exec_pkg::BYTE_ONE;

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = BYTE_ONE_F << idx;
  endfunction

  assign func = mcu_exec_pkg::func_t'(ir_r[mcu_exec_pkg::FUNC_MSB:mcu_exec_pkg::FUNC_LSB]);
  assign dest_mem = ir_r[mcu_exec_pkg::DEST_BIT];
  assign imm = ir_r[mcu_exec_pkg::BYTE_MSB:0];
  assign cyc_end = (phase_r == mcu_exec_pkg::PH_LAST);
  assign pc_low_wr = wr_r && (dm_addr_r == mcu_exec_pkg::PC_LOW_ADDR);

  always_comb
  begin
    is_imm = func inside {mcu_exec_pkg::F_ADD_IMM, mcu_exec_pkg::F_SUB_IMM,
      mcu_exec_pkg::F_AND_IMM, mcu_exec_pkg::F_OR_IMM, mcu_exec_pkg::F_XOR_IMM};
    sub_op = func inside {mcu_exec_pkg::F_SUBTRACT, mcu_exec_pkg::F_SUB_C,
      mcu_exec_pkg::F_SUB_IMM};
    bsel = is_imm ? imm : opnd_r;
    addend = sub_op ? ~bsel : bsel;
    cin = (func inside {mcu_exec_pkg::F_ADD_C, mcu_exec_pkg::F_SUB_C}) ? c_r : sub_op;
    sum9 = {1'b0, acc_r} + {1'b0, addend} + {8'h00, cin};
    half = {1'b0, acc_r[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
    res = opnd_r;
    use_d = 1'b1;
    a_we = 1'b0;
    m_we = 1'b0;
    rz = z_r;
    rc = c_r;
    rac = ac_r;
    rov = ov_r;
    rskip = 1'b0;
    case (func)
      mcu_exec_pkg::F_TRANSFER: res = dest_mem ? acc_r : opnd_r;
      mcu_exec_pkg::F_TRANSFER_IMM: res = imm;
      mcu_exec_pkg::F_ADD, mcu_exec_pkg::F_ADD_C, mcu_exec_pkg::F_ADD_IMM,
      mcu_exec_pkg::F_SUBTRACT, mcu_exec_pkg::F_SUB_C, mcu_exec_pkg::F_SUB_IMM:
      begin
        res = sum9[7:0];
        rz = (sum9[7:0] == mcu_exec_pkg::BYTE_ZERO);
        rc = sum9[8];
        rac = half[4];
        rov = (acc_r[7] == addend[7]) && (sum9[7] != acc_r[7]);
      end
      mcu_exec_pkg::F_AND, mcu_exec_pkg::F_AND_IMM: res = acc_r & bsel;
      mcu_exec_pkg::F_OR, mcu_exec_pkg::F_OR_IMM: res = acc_r | bsel;
      mcu_exec_pkg::F_XOR, mcu_exec_pkg::F_XOR_IMM: res = acc_r ^ bsel;
      mcu_exec_pkg::F_INVERT: res = ~opnd_r;
      mcu_exec_pkg::F_ADD_ONE: res = opnd_r + mcu_exec_pkg::BYTE_ONE;
      mcu_exec_pkg::F_SUB_ONE: res = opnd_r - mcu_exec_pkg::BYTE_ONE;
      mcu_exec_pkg::F_ROT_R: res = {opnd_r[0], opnd_r[7:1]};
      mcu_exec_pkg::F_ROT_L: res = {opnd_r[6:0], opnd_r[7]};
      mcu_exec_pkg::F_ROT_R_C:
      begin
        res = {c_r, opnd_r[7:1]};
        rc = opnd_r[0];
      end
      mcu_exec_pkg::F_ROT_L_C:
      begin
        res = {opnd_r[6:0], c_r};
        rc = opnd_r[7];
      end
      mcu_exec_pkg::F_BIT_CLR, mcu_exec_pkg::F_BIT_SET:
      begin
        use_d = 1'b0;
        m_we = 1'b1;
        res = (func == mcu_exec_pkg::F_BIT_SET)
          ? (opnd_r | bit_mask(ir_r[mcu_exec_pkg::BIT_MSB:mcu_exec_pkg::BIT_LSB]))
          : (opnd_r & ~bit_mask(ir_r[mcu_exec_pkg::BIT_MSB:mcu_exec_pkg::BIT_LSB]));
      end
      mcu_exec_pkg::F_CLEAR:
      begin
        use_d = 1'b0;
        m_we = 1'b1;
        res = mcu_exec_pkg::BYTE_ZERO;
      end
      mcu_exec_pkg::F_SKIP_Z:
      begin
        use_d = 1'b0;
        a_we = !dest_mem;
        rskip = (opnd_r == mcu_exec_pkg::BYTE_ZERO);
      end
      mcu_exec_pkg::F_SKIP_BIT_Z, mcu_exec_pkg::F_SKIP_BIT_NZ:
      begin
        use_d = 1'b0;
        rskip = ((opnd_r & bit_mask(ir_r[mcu_exec_pkg::BIT_MSB:mcu_exec_pkg::BIT_LSB]))
          == mcu_exec_pkg::BYTE_ZERO) == (func == mcu_exec_pkg::F_SKIP_BIT_Z);
      end
      mcu_exec_pkg::F_SKIP_INC_Z, mcu_exec_pkg::F_SKIP_DEC_Z:
      begin
        res = (func == mcu_exec_pkg::F_SKIP_INC_Z) ? opnd_r + mcu_exec_pkg::BYTE_ONE
          : opnd_r - mcu_exec_pkg::BYTE_ONE;
        rskip = (res == mcu_exec_pkg::BYTE_ZERO);
      end
      default: use_d = 1'b0;
    endcase
    if (func inside {mcu_exec_pkg::F_AND, mcu_exec_pkg::F_OR, mcu_exec_pkg::F_XOR,
      mcu_exec_pkg::F_AND_IMM, mcu_exec_pkg::F_OR_IMM, mcu_exec_pkg::F_XOR_IMM,
      mcu_exec_pkg::F_INVERT, mcu_exec_pkg::F_ADD_ONE, mcu_exec_pkg::F_SUB_ONE})
      rz = (res == mcu_exec_pkg::BYTE_ZERO);
    if (use_d)
    begin
      m_we = dest_mem && !is_imm && (func != mcu_exec_pkg::F_TRANSFER_IMM);
      a_we = !m_we;
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb
  begin
    state_nxt = state_r;
    phase_nxt = phase_r + 2'h1;
    pc_nxt = pc_r;
    ir_nxt = ir_r;
    dm_addr_nxt = dm_addr_r;
    opnd_nxt = opnd_r;
    acc_nxt = acc_r;
    z_nxt = z_r;
    c_nxt = c_r;
    ac_nxt = ac_r;
    ov_nxt = ov_r;
    wdata_nxt = wdata_r;
    wr_nxt = 1'b0;
    skip_nxt = skip_r;
    sp_nxt = sp_r;
    push = 1'b0;
    if (phase_r == mcu_exec_pkg::PH_READ)
      opnd_nxt = DATA_RDATA_IN;
    if (phase_r == mcu_exec_pkg::PH_EXEC && state_r == mcu_exec_pkg::ST_RUN)
    begin
      if (a_we)
        acc_nxt = res;
      wdata_nxt = res;
      wr_nxt = m_we;
      z_nxt = rz;
      c_nxt = rc;
      ac_nxt = rac;
      ov_nxt = rov;
      skip_nxt = rskip;
    end
    else if (phase_r == mcu_exec_pkg::PH_EXEC && state_r == mcu_exec_pkg::ST_TABLE)
    begin
      wdata_nxt = PROG_DATA_IN[mcu_exec_pkg::BYTE_MSB:0];
      wr_nxt = 1'b1;
    end
    if (cyc_end)
    begin
      skip_nxt = 1'b0;
      case (state_r)
        mcu_exec_pkg::ST_RUN:
        begin
          state_nxt = mcu_exec_pkg::ST_FLUSH;
          if (pc_low_wr)
            pc_nxt = {pc_r[PC_W-1:8], wdata_r};
          else if (func == mcu_exec_pkg::F_JUMP)
            pc_nxt = ir_r[PC_W-1:0];
          else if (func == mcu_exec_pkg::F_CALL)
          begin
            push = 1'b1;
            sp_nxt = sp_r + 1'b1;
            pc_nxt = ir_r[PC_W-1:0];
          end
          else if (func inside {mcu_exec_pkg::F_SUB_EXIT, mcu_exec_pkg::F_INT_EXIT})
          begin
            sp_nxt = sp_r - 1'b1;
            pc_nxt = stack_r[sp_r - 1'b1];
          end
          else if (func == mcu_exec_pkg::F_POWER_DOWN)
            state_nxt = mcu_exec_pkg::ST_HALT;
          else if (skip_r)
            pc_nxt = pc_r + 1'b1;
          else
          begin
            ir_nxt = PROG_DATA_IN;
            pc_nxt = pc_r + 1'b1;
            state_nxt = (func == mcu_exec_pkg::F_TABLE_RD) ? mcu_exec_pkg::ST_TABLE
              : mcu_exec_pkg::ST_RUN;
            if (func != mcu_exec_pkg::F_TABLE_RD)
              dm_addr_nxt = PROG_DATA_IN[mcu_exec_pkg::BYTE_MSB:0];
          end
        end
        mcu_exec_pkg::ST_FLUSH:
        begin
          ir_nxt = PROG_DATA_IN;
          dm_addr_nxt = PROG_DATA_IN[mcu_exec_pkg::BYTE_MSB:0];
          pc_nxt = pc_r + 1'b1;
          state_nxt = mcu_exec_pkg::ST_RUN;
        end
        mcu_exec_pkg::ST_TABLE:
        begin
          dm_addr_nxt = imm;
          state_nxt = mcu_exec_pkg::ST_RUN;
        end
        mcu_exec_pkg::ST_HALT:
          if (wake_sync_r)
            state_nxt = mcu_exec_pkg::ST_FLUSH;
        default: state_nxt = mcu_exec_pkg::ST_FLUSH;
      endcase
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    wake_meta_r <= WAKE_IN;
    wake_sync_r <= wake_meta_r;
    if (push)
      stack_r[sp_r] <= pc_r;
    if (RESET_IN)
    begin
      state_r <= mcu_exec_pkg::ST_FLUSH;
      phase_r <= 2'h0;
      pc_r <= '0;
      ir_r <= '0;
      dm_addr_r <= mcu_exec_pkg::BYTE_ZERO;
      opnd_r <= mcu_exec_pkg::BYTE_ZERO;
      acc_r <= mcu_exec_pkg::BYTE_ZERO;
      {z_r, c_r, ac_r, ov_r} <= 4'h0;
      wdata_r <= mcu_exec_pkg::BYTE_ZERO;
      wr_r <= 1'b0;
      skip_r <= 1'b0;
      sp_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      pc_r <= pc_nxt;
      ir_r <= ir_nxt;
      dm_addr_r <= dm_addr_nxt;
      opnd_r <= opnd_nxt;
      acc_r <= acc_nxt;
      {z_r, c_r, ac_r, ov_r} <= {z_nxt, c_nxt, ac_nxt, ov_nxt};
      wdata_r <= wdata_nxt;
      wr_r <= wr_nxt;
      skip_r <= skip_nxt;
      sp_r <= sp_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign PROG_ADDR_OUT = (state_r == mcu_exec_pkg::ST_TABLE) ? {pc_r[PC_W-1:8], acc_r} : pc_r;
  assign DATA_ADDR_OUT = dm_addr_r;
  assign DATA_WDATA_OUT = wdata_r;
  assign DATA_WR_OUT = wr_r;
  assign ACC_OUT = acc_r;
  assign {ZERO_OUT, CARRY_OUT, AUX_CARRY_OUT, OVERFLOW_OUT} = {z_r, c_r, ac_r, ov_r};
  assign HALTED_OUT = (state_r == mcu_exec_pkg::ST_HALT);
  assign CYCLE_END_OUT = cyc_end;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  logic run_exec;
  assign run_exec = (state_r == mcu_exec_pkg::ST_RUN) && (phase_r == mcu_exec_pkg::PH_EXEC);

  cycle_length_a: assert property (cyc_end |=> !cyc_end [*3] ##1 cyc_end)
    else $error("instruction cycle is not four clocks");
  jump_timing_a: assert property (cyc_end && state_r == mcu_exec_pkg::ST_RUN && !pc_low_wr
    && func == mcu_exec_pkg::F_JUMP |=> pc_r == $past(ir_r[PC_W-1:0]) && sp_r == $past(sp_r)
    ##0 (state_r == mcu_exec_pkg::ST_FLUSH) [*4] ##1 state_r == mcu_exec_pkg::ST_RUN)
    else $error("jump did not take two cycles to its target");
  jump_flags_a: assert property (run_exec && func == mcu_exec_pkg::F_JUMP
    |=> $stable({z_r, c_r, ac_r, ov_r}))
    else $error("jump changed a flag");
  pc_low_write_a: assert property (cyc_end && state_r == mcu_exec_pkg::ST_RUN && pc_low_wr
    |=> pc_r[7:0] == $past(wdata_r) && state_r == mcu_exec_pkg::ST_FLUSH)
    else $error("program counter low byte write did not redirect");
  skip_taken_a: assert property (cyc_end && state_r == mcu_exec_pkg::ST_RUN && skip_r
    && !pc_low_wr |=> state_r == mcu_exec_pkg::ST_FLUSH && pc_r == $past(pc_r) + 1'b1)
    else $error("taken skip did not discard the next instruction");
  add_flags_a: assert property (run_exec && func == mcu_exec_pkg::F_ADD && !dest_mem
    |=> c_r == (({1'b0, $past(acc_r)} + {1'b0, $past(opnd_r)}) > mcu_exec_pkg::BYTE_MAX)
    && acc_r == $past(acc_r) + $past(opnd_r) && z_r == (acc_r == mcu_exec_pkg::BYTE_ZERO))
    else $error("add result or flags wrong");
  add_one_a: assert property (run_exec && func == mcu_exec_pkg::F_ADD_ONE && !dest_mem
    |=> acc_r == $past(opnd_r) + mcu_exec_pkg::BYTE_ONE)
    else $error("add one did not step by one");
  logic_and_a: assert property (run_exec && func == mcu_exec_pkg::F_AND && !dest_mem
    |=> acc_r == ($past(acc_r) & $past(opnd_r)) && z_r == (acc_r == mcu_exec_pkg::BYTE_ZERO))
    else $error("and result or zero flag wrong");
  rotate_carry_a: assert property (run_exec && func == mcu_exec_pkg::F_ROT_R_C && dest_mem
    |=> c_r == $past(opnd_r[0]) && wdata_r == {$past(c_r), $past(opnd_r[7:1])} && wr_r)
    else $error("rotate through carry wrong");
  rotate_plain_a: assert property (run_exec && func == mcu_exec_pkg::F_ROT_L && !dest_mem
    |=> $stable({z_r, c_r, ac_r, ov_r}) && acc_r == {$past(opnd_r[6:0]), $past(opnd_r[7])})
    else $error("plain rotate wrong or touched flags");
  call_exit_a: assert property (cyc_end && state_r == mcu_exec_pkg::ST_RUN && !pc_low_wr
    && func inside {mcu_exec_pkg::F_SUB_EXIT, mcu_exec_pkg::F_INT_EXIT} |=> pc_r == stack_r[sp_r])
    else $error("exit did not resume at saved address");
  bit_set_a: assert property (run_exec && func == mcu_exec_pkg::F_BIT_SET |=> wr_r
    && wdata_r == ($past(opnd_r)
    | bit_mask($past(ir_r[mcu_exec_pkg::BIT_MSB:mcu_exec_pkg::BIT_LSB]))))
    else $error("bit set changed other bits");
  table_read_a: assert property (state_r == mcu_exec_pkg::ST_TABLE
    && phase_r == mcu_exec_pkg::PH_EXEC
    |=> wr_r && wdata_r == $past(PROG_DATA_IN[mcu_exec_pkg::BYTE_MSB:0]))
    else $error("table byte not delivered");
  power_down_a: assert property (cyc_end && state_r == mcu_exec_pkg::ST_RUN && !pc_low_wr
    && func == mcu_exec_pkg::F_POWER_DOWN |=> HALTED_OUT)
    else $error("power down not entered");

endmodule // mcu_instruction_execution

// ==== sim/mem_partner.sv ====
// Purpose: Program memory and data memory facing the execution core
// Assumes: Both memories answer from the address with no wait
// Notes: The bench loads both arrays directly and inspects the data array
`timescale 1ns/10ps
module mem_partner (
  input wire logic clk_in,
  input wire logic [11:0] prog_addr_in,
  output logic [18:0] prog_data_out,
  input wire logic [7:0] data_addr_in,
  output logic [7:0] data_rdata_out,
  input wire logic [7:0] data_wdata_in,
  input wire logic data_wr_in
);
  // ****************************************
  // Storage
  // ****************************************
  logic [18:0] rom [0:4095];
  logic [7:0] ram [0:255];
  assign prog_data_out = rom[prog_addr_in];
  assign data_rdata_out = ram[data_addr_in];
  always @(posedge clk_in)
  begin
    if (data_wr_in === 1'b1)
    begin
      ram[data_addr_in] <= data_wdata_in;
    end
  end
endmodule // mem_partner

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench for the instruction execution core
// Assumes: Cycle costs are measured against a lone power-down program
// Notes: Flags are compared as one byte {zero, carry, aux, overflow}, in t_arith as {zero, carry}
`timescale 1ns/10ps
module testbench;
  logic clk;
  logic rst;
  logic wake;
  logic [11:0] pa;
  logic [18:0] pd;
  logic [7:0] da;
  logic [7:0] dr;
  logic [7:0] dw;
  logic [7:0] acc;
  logic wr, z, c, ac, ov, hlt, ce;
  int fail_count = 0;
  int checks_done = 0;
  int base = 0;
  int cyc = 0;
  int gap = 0;
  int ticks = 0;

  mcu_instruction_execution mcu_instruction_execution_i (
    .CLK_IN(clk), .RESET_IN(rst), .WAKE_IN(wake), .PROG_ADDR_OUT(pa),
    .PROG_DATA_IN(pd), .DATA_ADDR_OUT(da), .DATA_RDATA_IN(dr),
    .DATA_WDATA_OUT(dw), .DATA_WR_OUT(wr), .ACC_OUT(acc), .ZERO_OUT(z),
    .CARRY_OUT(c), .AUX_CARRY_OUT(ac), .OVERFLOW_OUT(ov),
    .HALTED_OUT(hlt), .CYCLE_END_OUT(ce));

  mem_partner mem_partner_i (
    .clk_in(clk), .prog_addr_in(pa), .prog_data_out(pd), .data_addr_in(da),
    .data_rdata_out(dr), .data_wdata_in(dw), .data_wr_in(wr));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask

  always @(posedge clk)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      fail_count++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic op(input int a, input logic d, input mcu_exec_pkg::func_t f,
    input logic [10:0] x);
    mem_partner_i.rom[a] = {d, f, 1'b0, x};
  endtask

  task automatic clr();
    for (int i = 0; i < 4096; i++) mem_partner_i.rom[i] = 19'h00000;
    for (int i = 0; i < 256; i++) mem_partner_i.ram[i] = 8'h00;
  endtask

  // Resets, then counts cycle ends until power-down is reached
  task automatic run();
    int last;
    last = 0;
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    cyc = 0;
    for (int n = 0; n < 300 && hlt !== 1'b1; n++)
    begin
      @(negedge clk);
      if (ce === 1'b1)
      begin
        cyc++;
        gap = n - last;
        last = n;
      end
    end
    check({7'h00, hlt}, 8'h01);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_base();
    clr();
    op(0, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    base = cyc;
    clr();
    op(2, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h02);
    check(8'(gap), 8'h04);
  endtask

  task automatic t_jump();
    clr();
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h0ff);
    op(1, 1'b0, mcu_exec_pkg::F_ADD_IMM, 11'h001);
    op(2, 1'b0, mcu_exec_pkg::F_JUMP, 11'h010);
    op(3, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h055);
    op(16, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h04);
    check(acc, 8'h00);
    check({4'h0, z, c, ac, ov}, 8'h0e);
  endtask

  task automatic t_call(input mcu_exec_pkg::func_t f);
    clr();
    op(0, 1'b0, mcu_exec_pkg::F_CALL, 11'h020);
    op(1, 1'b0, mcu_exec_pkg::F_ADD_IMM, 11'h022);
    op(2, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    op(32, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h011);
    op(33, 1'b0, f, 11'h000);
    run();
    check(8'(cyc - base), 8'h06);
    check(acc, 8'h33);
  endtask

  task automatic t_skip(input mcu_exec_pkg::func_t f, input logic [7:0] v,
    input logic [2:0] b, input logic t);
    clr();
    mem_partner_i.ram[64] = v;
    op(0, 1'b1, f, {b, 8'h40});
    op(1, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h077);
    op(2, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h02);
    check(acc, t ? 8'h00 : 8'h77);
  endtask

  task automatic t_arith();
    clr();
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h010);
    op(1, 1'b0, mcu_exec_pkg::F_SUB_IMM, 11'h020);
    op(2, 1'b1, mcu_exec_pkg::F_TRANSFER, 11'h041);
    op(3, 1'b1, mcu_exec_pkg::F_ADD_ONE, 11'h041);
    op(4, 1'b0, mcu_exec_pkg::F_SUB_ONE, 11'h041);
    op(5, 1'b1, mcu_exec_pkg::F_ROT_L_C, 11'h041);
    op(6, 1'b1, mcu_exec_pkg::F_BIT_CLR, 11'h141);
    op(7, 1'b1, mcu_exec_pkg::F_BIT_SET, 11'h341);
    op(8, 1'b0, mcu_exec_pkg::F_XOR, 11'h041);
    op(9, 1'b0, mcu_exec_pkg::F_AND_IMM, 11'h000);
    op(10, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h0a);
    check(mem_partner_i.ram[65], 8'he8);
    check(acc, 8'h00);
    check({6'h00, z, c}, 8'h03);
  endtask

  task automatic t_misc();
    clr();
    mem_partner_i.ram[66] = 8'h80;
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h0ff);
    op(1, 1'b0, mcu_exec_pkg::F_ADD_IMM, 11'h001);
    op(2, 1'b0, mcu_exec_pkg::F_ROT_R, 11'h042);
    op(3, 1'b1, mcu_exec_pkg::F_ROT_R_C, 11'h042);
    op(4, 1'b0, mcu_exec_pkg::F_ROT_L, 11'h042);
    op(5, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(acc, 8'h81);
    check(mem_partner_i.ram[66], 8'hc0);
    check({4'h0, z, c, ac, ov}, 8'h0a);
    clr();
    mem_partner_i.ram[68] = 8'h01;
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h07f);
    op(1, 1'b0, mcu_exec_pkg::F_ADD, 11'h044);
    op(2, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h02);
    check({acc[7:4], z, c, ac, ov}, 8'h83);
  endtask

  task automatic t_logic();
    clr();
    mem_partner_i.ram[69] = 8'h0f;
    mem_partner_i.ram[70] = 8'hf0;
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER, 11'h045);
    op(1, 1'b0, mcu_exec_pkg::F_XOR_IMM, 11'h03c);
    op(2, 1'b0, mcu_exec_pkg::F_OR_IMM, 11'h0c0);
    op(3, 1'b1, mcu_exec_pkg::F_OR, 11'h046);
    op(4, 1'b0, mcu_exec_pkg::F_AND, 11'h046);
    op(5, 1'b0, mcu_exec_pkg::F_ADD_ONE, 11'h046);
    op(6, 1'b1, mcu_exec_pkg::F_INVERT, 11'h046);
    op(7, 1'b0, mcu_exec_pkg::F_SUBTRACT, 11'h045);
    op(8, 1'b0, mcu_exec_pkg::F_ADD_C, 11'h045);
    op(9, 1'b1, mcu_exec_pkg::F_SUB_C, 11'h046);
    op(10, 1'b1, mcu_exec_pkg::F_CLEAR, 11'h045);
    op(11, 1'b0, mcu_exec_pkg::F_SKIP_Z, 11'h045);
    op(12, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h055);
    op(13, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h0d);
    check(mem_partner_i.ram[70], 8'he8);
    check(mem_partner_i.ram[69], 8'h00);
    check(acc, 8'h00);
    check({4'h0, z, c, ac, ov}, 8'h04);
  endtask

  task automatic t_redirect();
    clr();
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h010);
    op(1, 1'b1, mcu_exec_pkg::F_TRANSFER, 11'h002);
    op(2, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h055);
    op(16, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h03);
    check(acc, 8'h10);
    clr();
    mem_partner_i.rom[48] = 19'h7f0a5;
    op(0, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h030);
    op(1, 1'b1, mcu_exec_pkg::F_TABLE_RD, 11'h043);
    op(2, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    check(8'(cyc - base), 8'h03);
    check(mem_partner_i.ram[67], 8'ha5);
  endtask

  task automatic t_wake();
    int n;
    clr();
    op(0, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    op(1, 1'b0, mcu_exec_pkg::F_TRANSFER_IMM, 11'h066);
    op(2, 1'b0, mcu_exec_pkg::F_POWER_DOWN, 11'h000);
    run();
    repeat (12) @(negedge clk);
    check({7'h00, hlt}, 8'h01);
    check(acc, 8'h00);
    @(posedge clk);
    #1 wake = 1'b1;
    for (n = 0; n < 40 && hlt !== 1'b0; n++) @(negedge clk);
    @(posedge clk);
    #1 wake = 1'b0;
    for (n = 0; n < 40 && hlt !== 1'b1; n++) @(negedge clk);
    check({7'h00, hlt}, 8'h01);
    check(acc, 8'h66);
  endtask

  initial
  begin
    rst = 1'b1;
    wake = 1'b0;
    t_base();
    t_jump();
    t_call(mcu_exec_pkg::F_SUB_EXIT);
    t_call(mcu_exec_pkg::F_INT_EXIT);
    t_skip(mcu_exec_pkg::F_SKIP_Z, 8'h00, 3'h0, 1'b1);
    t_skip(mcu_exec_pkg::F_SKIP_Z, 8'h05, 3'h0, 1'b0);
    t_skip(mcu_exec_pkg::F_SKIP_BIT_Z, 8'hf7, 3'h3, 1'b1);
    t_skip(mcu_exec_pkg::F_SKIP_BIT_NZ, 8'hf7, 3'h3, 1'b0);
    t_skip(mcu_exec_pkg::F_SKIP_INC_Z, 8'hff, 3'h0, 1'b1);
    t_skip(mcu_exec_pkg::F_SKIP_DEC_Z, 8'h02, 3'h0, 1'b0);
    t_arith();
    t_misc();
    t_logic();
    t_redirect();
    t_wake();
    stop_test();
  end
endmodule // testbench
